/* File: logic/err_flag_if.sv */
`timescale 1ns/1ps
interface err_flag_if;
  import rxstat_pkg::*;
  logic [NUM_ERR-1:0] set;
  logic [NUM_ERR-1:0] clr;
  logic [NUM_ERR-1:0] flags;
  modport producer (output set, output clr, input flags);
  modport bank (input set, input clr, output flags);
endinterface : err_flag_if

/* File: logic/flag_bank.sv */
`timescale 1ns/1ps
module flag_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flag events and state
  err_flag_if.bank f
);
  import rxstat_pkg::*;
  logic [NUM_ERR-1:0] flags_ff;

  // A new error beats a clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flags_ff <= '0;
    else
      flags_ff <= f.set | (flags_ff & ~f.clr);
  end

  assign f.flags = flags_ff;
endmodule : flag_bank

/* File: logic/rx_readback.sv */
// Operation
// - Master drops select on ready timeout, flags it.
// - Timeout flag reads zero outside master mode.
// - Parity flag reads one after parity error.
// - Length flag sits at buffer bit 24.
// - Reading received word clears error flags.
// - Buffer bits 23-16 read zero, ignore writes.
// - Completed transfer loads word into bits 15-0.
// - Received word stored right-justified always.
// - Mirror returns word, upper bits read zero.
// - Mirror read leaves every flag unchanged.
// - Parity mismatch on received word sets flag.
// - Own transmit pin echo mismatch sets flag.
`timescale 1ns/1ps
module rx_readback (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Shift engine, same clock
  input wire logic XFER_DONE,
  input wire logic [rxstat_pkg::RXD_W-1:0] RX_SHIFT,
  input wire logic RX_PARITY,
  input wire logic DLEN_ERR,
  input wire logic CS_REQ,
  input wire logic TX_BIT,
  input wire logic ECHO_STROBE,
  // Pins
  input wire logic SLAVE_READY_N,
  input wire logic TX_PIN,
  output logic CS_N,
  // To the shift engine and the system
  output logic XFER_GO,
  output logic IRQ
);
  import rxstat_pkg::*;

  logic [31:0] ctrl_ff;
  logic [INT_W-1:0] int_stat_ff;
  logic [INT_W-1:0] int_en_ff;
  logic [INT_W-1:0] nxt_int_stat;
  logic irq_ff;
  logic [RXD_W-1:0] rxword_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic rd_clr;
  logic master;
  logic [LEN_W-1:0] eff_len;
  logic [LEN_W-1:0] shamt;
  logic [RXD_W:0] len_mask;
  logic [RXD_W-1:0] just_word;
  logic par_calc;
  logic par_bad;
  logic ready_s;
  logic tx_pin_s;
  logic [1:0] tx_bit_dly_ff;
  logic [1:0] echo_stb_dly_ff;
  logic echo_bad;
  cs_state_t cs_state_ff;
  logic [TMO_W-1:0] tmo_cnt_ff;
  logic cs_n_ff;
  logic go_ff;
  logic req;
  logic tmo_hit;

  err_flag_if errs ();

  flag_bank u_flags (
    .clk(CLK),
    .rst_n(RST_N),
    .f(errs.bank)
  );

  sync2 u_ready_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(~SLAVE_READY_N),
    .q(ready_s)
  );

  sync2 u_echo_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(TX_PIN),
    .q(tx_pin_s)
  );

  assign master = ctrl_ff[CTRL_MASTER_BIT];

  // APB decode. Reads are taken on the first access cycle so that the
  // returned data and the flag clear see the same flag state.
  always_comb
  begin
    addr_ok = (PADDR == ADDR_RXBUF) || (PADDR == ADDR_MIRROR) ||
              (PADDR == ADDR_CTRL) || (PADDR == ADDR_INTSTAT) ||
              (PADDR == ADDR_INTCLR) || (PADDR == ADDR_INTEN);
    rd_take = PSEL && PENABLE && !pready_ff && !PWRITE;
    wr_take = PSEL && PENABLE && pready_ff && PWRITE && addr_ok;
    rd_clr = rd_take && (PADDR == ADDR_RXBUF);
  end

  always_comb
  begin
    rd_mux = '0;
    unique case (PADDR)
      ADDR_RXBUF:
      begin
        rd_mux[RXD_W-1:0] = rxword_ff;
        rd_mux[BUF_DLEN_BIT] = errs.flags[ERR_DLEN];
        rd_mux[BUF_TMO_BIT] = errs.flags[ERR_TMO] && master;
        rd_mux[BUF_PAR_BIT] = errs.flags[ERR_PAR];
        rd_mux[BUF_ECHO_BIT] = errs.flags[ERR_ECHO];
      end
      ADDR_MIRROR:
      begin
        rd_mux[RXD_W-1:0] = rxword_ff;
      end
      ADDR_CTRL:
      begin
        rd_mux = ctrl_ff;
      end
      ADDR_INTSTAT:
      begin
        rd_mux[INT_W-1:0] = int_stat_ff;
      end
      ADDR_INTEN:
      begin
        rd_mux[INT_W-1:0] = int_en_ff;
      end
      default:
      begin
        rd_mux = '0;
      end
    endcase
  end

  // One wait state on every access keeps PREADY a plain flip-flop.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= PSEL && PENABLE && !pready_ff;
      pslverr_ff <= PSEL && PENABLE && !pready_ff && !addr_ok;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      prdata_ff <= '0;
    else if (rd_take)
      prdata_ff <= rd_mux;
  end

  // Only the control and interrupt enable registers store writes.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ctrl_ff <= CTRL_RST;
    else if (wr_take && PADDR == ADDR_CTRL)
      ctrl_ff <= PWDATA;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      int_en_ff <= INTEN_RST;
    else if (wr_take && PADDR == ADDR_INTEN)
      int_en_ff <= PWDATA[INT_W-1:0];
  end

  // Right justification. A length of zero or above sixteen counts as sixteen.
  always_comb
  begin
    eff_len = ctrl_ff[CTRL_LEN_LSB +: LEN_W];
    if (eff_len == 5'h00 || eff_len > 5'h10)
      eff_len = 5'h10;
    shamt = 5'h10 - eff_len;
    len_mask = (17'h00001 << eff_len) - 17'h00001;
    if (ctrl_ff[CTRL_LSBF_BIT])
      just_word = (RX_SHIFT >> shamt) & len_mask[RXD_W-1:0];
    else
      just_word = RX_SHIFT & len_mask[RXD_W-1:0];
    par_calc = (^just_word) ^ ctrl_ff[CTRL_PARODD_BIT];
    par_bad = XFER_DONE && ctrl_ff[CTRL_PAREN_BIT] && (par_calc != RX_PARITY);
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rxword_ff <= '0;
    else if (XFER_DONE)
      rxword_ff <= just_word;
  end

  // The pin sample is two cycles late after its synchroniser, so the
  // driven bit and the sample strobe are delayed by the same amount.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      tx_bit_dly_ff <= '0;
      echo_stb_dly_ff <= '0;
    end
    else
    begin
      tx_bit_dly_ff <= {tx_bit_dly_ff[0], TX_BIT};
      echo_stb_dly_ff <= {echo_stb_dly_ff[0], ECHO_STROBE};
    end
  end

  assign echo_bad = echo_stb_dly_ff[1] && (tx_pin_s != tx_bit_dly_ff[1]);

  // Chip select control with the slave ready watchdog.
  // Ready arriving after a timeout is ignored until the request drops, so the
  // engine never starts shifting on a select that has already been released.
  assign req = CS_REQ && master;
  assign tmo_hit = (cs_state_ff == CS_WAIT) && req && !ready_s && (tmo_cnt_ff == TMO_LAST);

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cs_state_ff <= CS_IDLE;
      tmo_cnt_ff <= '0;
      cs_n_ff <= 1'b1;
      go_ff <= 1'b0;
    end
    else
    begin
      unique case (cs_state_ff)
        CS_IDLE:
        begin
          tmo_cnt_ff <= '0;
          if (req)
          begin
            cs_n_ff <= 1'b0;
            go_ff <= !ctrl_ff[CTRL_ENACHK_BIT];
            cs_state_ff <= ctrl_ff[CTRL_ENACHK_BIT] ? CS_WAIT : CS_LIVE;
          end
        end
        CS_WAIT:
        begin
          if (!req)
          begin
            cs_n_ff <= 1'b1;
            cs_state_ff <= CS_IDLE;
          end
          else if (ready_s)
          begin
            go_ff <= 1'b1;
            cs_state_ff <= CS_LIVE;
          end
          else if (tmo_hit)
          begin
            cs_n_ff <= 1'b1;
            cs_state_ff <= CS_EXPIRED;
          end
          else
            tmo_cnt_ff <= tmo_cnt_ff + 8'h01;
        end
        CS_LIVE:
        begin
          if (!req)
          begin
            cs_n_ff <= 1'b1;
            go_ff <= 1'b0;
            cs_state_ff <= CS_IDLE;
          end
        end
        CS_EXPIRED:
        begin
          // Select stays released until the engine withdraws its request.
          if (!req)
            cs_state_ff <= CS_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    errs.set = '0;
    errs.set[ERR_DLEN] = DLEN_ERR;
    errs.set[ERR_TMO] = tmo_hit;
    errs.set[ERR_PAR] = par_bad;
    errs.set[ERR_ECHO] = echo_bad;
    errs.clr = {NUM_ERR{rd_clr}};
  end

  // Interrupt status: events set, write-one-to-clear, set wins.
  always_comb
  begin
    nxt_int_stat = int_stat_ff;
    if (wr_take && PADDR == ADDR_INTCLR)
      nxt_int_stat = int_stat_ff & ~PWDATA[INT_W-1:0];
    nxt_int_stat[INT_RXDONE_BIT] = nxt_int_stat[INT_RXDONE_BIT] | XFER_DONE;
    nxt_int_stat[INT_ERR_LSB +: NUM_ERR] = nxt_int_stat[INT_ERR_LSB +: NUM_ERR] | errs.set;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      int_stat_ff <= '0;
    else
      int_stat_ff <= nxt_int_stat;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_int_stat & int_en_ff);
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign CS_N = cs_n_ff;
  assign XFER_GO = go_ff;
  assign IRQ = irq_ff;
endmodule : rx_readback

/* File: logic/rxstat_pkg.sv */
package rxstat_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_RXBUF = 8'h00;
  localparam logic [7:0] ADDR_MIRROR = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_INTSTAT = 8'h0c;
  localparam logic [7:0] ADDR_INTCLR = 8'h10;
  localparam logic [7:0] ADDR_INTEN = 8'h14;
  // Receive buffer register layout.
  localparam int RXD_W = 16;
  localparam int BUF_DLEN_BIT = 24;
  localparam int BUF_TMO_BIT = 25;
  localparam int BUF_PAR_BIT = 26;
  localparam int BUF_ECHO_BIT = 28;
  // Control register layout.
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_ENACHK_BIT = 1;
  localparam int CTRL_PAREN_BIT = 2;
  localparam int CTRL_PARODD_BIT = 3;
  localparam int CTRL_LSBF_BIT = 4;
  localparam int CTRL_LEN_LSB = 8;
  localparam int LEN_W = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_1000;
  // Error flag indices.
  localparam int ERR_DLEN = 0;
  localparam int ERR_TMO = 1;
  localparam int ERR_PAR = 2;
  localparam int ERR_ECHO = 3;
  localparam int NUM_ERR = 4;
  // Interrupt status layout: bit 0 receive done, bits 4:1 the error flags.
  localparam int INT_RXDONE_BIT = 0;
  localparam int INT_ERR_LSB = 1;
  localparam int INT_W = 5;
  localparam logic [INT_W-1:0] INTEN_RST = 5'h00;
  // Slave ready wait, a least time rounded up to whole cycles.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TMO_NS = 1000;
  localparam int TMO_CYC = (TMO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMO_W = 8;
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_LIVE, CS_EXPIRED} cs_state_t;
endpackage : rxstat_pkg

/* File: logic/sync2.sv */
`timescale 1ns/1ps
module sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : sync2

/* File: verification/rx_readback_asserts.sv */
`timescale 1ns/1ps
module rx_readback_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  // Engine and pins
  input wire logic XFER_DONE,
  input wire logic [rxstat_pkg::RXD_W-1:0] RX_SHIFT,
  input wire logic RX_PARITY,
  input wire logic DLEN_ERR,
  input wire logic CS_REQ,
  input wire logic SLAVE_READY_N,
  input wire logic CS_N,
  input wire logic XFER_GO
);
  import rxstat_pkg::*;
  logic rd0;
  logic rdm;
  logic pbad;
  logic dl_ff;
  logic pe_ff;
  logic seen_ff;
  logic [7:0] cnt_ff;
  logic [15:0] wd_ff;
  logic [31:0] ctl_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  function automatic logic [15:0] rx_exp(logic [15:0] s, logic [31:0] c);
    logic [4:0] n;
    n = c[CTRL_LEN_LSB +: LEN_W];
    if (n == 5'h00 || n > 5'h10) n = 5'h10;
    if (c[CTRL_LSBF_BIT]) s = s >> (5'h10 - n);
    return s & 16'((17'h1 << n) - 17'h1);
  endfunction : rx_exp
  assign rd0 = PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ADDR_RXBUF;
  assign rdm = PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ADDR_MIRROR;
  assign pbad = ^rx_exp(RX_SHIFT, ctl_ff) ^ ctl_ff[CTRL_PARODD_BIT] ^ RX_PARITY;
  // A new error beats a clearing read, so set is tested before clear.
  always_ff @(posedge CLK)
  begin
    if (!RST_N) ctl_ff <= CTRL_RST;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_CTRL) ctl_ff <= PWDATA;
    if (!RST_N) wd_ff <= 16'h0000;
    else if (XFER_DONE) wd_ff <= rx_exp(RX_SHIFT, ctl_ff);
    if (!RST_N) dl_ff <= 1'b0;
    else if (DLEN_ERR) dl_ff <= 1'b1;
    else if (rd0) dl_ff <= 1'b0;
    if (!RST_N) pe_ff <= 1'b0;
    else if (XFER_DONE && ctl_ff[CTRL_PAREN_BIT] && pbad) pe_ff <= 1'b1;
    else if (rd0) pe_ff <= 1'b0;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_N || CS_N) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
    if (!RST_N || CS_N) seen_ff <= 1'b0;
    else if (!SLAVE_READY_N) seen_ff <= 1'b1;
  end
  property p_r1; !seen_ff && ctl_ff[CTRL_ENACHK_BIT] |-> cnt_ff < 8'hd0; endproperty
  a_r1: assert property (p_r1) else $error("select held past wait");
  property p_slv; !ctl_ff[0] && !$past(ctl_ff[0]) |-> CS_N && !XFER_GO; endproperty
  a_slv: assert property (p_slv) else $error("select in slave mode");
  // Read data is taken at the first access edge, so flags are compared one cycle back.
  property p_r2; rd0 && !ctl_ff[CTRL_MASTER_BIT] |=> !PRDATA[BUF_TMO_BIT]; endproperty
  a_r2: assert property (p_r2) else $error("timeout bit in slave");
  property p_r3; rd0 |=> PRDATA[BUF_PAR_BIT] == $past(pe_ff); endproperty
  a_r3: assert property (p_r3) else $error("parity bit wrong");
  property p_r4; rd0 |=> PREADY && PRDATA[BUF_DLEN_BIT] == $past(dl_ff); endproperty
  a_r4: assert property (p_r4) else $error("length bit wrong");
  property p_r6; rd0 |=> PRDATA[23:16] == 8'h00; endproperty
  a_r6: assert property (p_r6) else $error("reserved bits set");
  property p_r7; rd0 && !XFER_DONE |=> PRDATA[15:0] == $past(wd_ff); endproperty
  a_r7: assert property (p_r7) else $error("buffer word wrong");
  property p_r9; rdm && !XFER_DONE |=> PRDATA == {16'h0000, $past(wd_ff)}; endproperty
  a_r9: assert property (p_r9) else $error("mirror word wrong");
  c_tmo: cover property ($rose(CS_N) && $past(CS_REQ));
  c_par: cover property (rd0 ##1 PRDATA[BUF_PAR_BIT]);
  c_mir: cover property (rdm);
endmodule : rx_readback_asserts
bind rx_readback rx_readback_asserts u_chk (.*);

/* File: verification/slave_model.sv */
`timescale 1ns/1ps
module slave_model (
  // Clock and select
  input wire logic clk,
  input wire logic cs_n,
  // Answer delay in cycles, 8'hff never answers
  input wire logic [7:0] delay,
  // Ready pin
  output logic ready_n
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk)
  begin
    if (cs_n !== 1'b0) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
  end
  // The pin has a pull-up, so it rests high whenever the slave is not selected.
  assign ready_n = (cs_n !== 1'b0) || delay == 8'hff || cnt_ff < delay;
endmodule : slave_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import rxstat_pkg::*;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, XFER_DONE, RX_PARITY, er;
  logic DLEN_ERR, CS_REQ, TX_BIT, ECHO_STROBE, SLAVE_READY_N, TX_PIN, CS_N, XFER_GO, IRQ;
  logic [7:0] PADDR, dly;
  logic [15:0] RX_SHIFT;
  logic [31:0] PWDATA, PRDATA, q;
  int errors, total_checks, n;
  rx_readback i_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .XFER_DONE(XFER_DONE), .RX_SHIFT(RX_SHIFT), .RX_PARITY(RX_PARITY),
    .DLEN_ERR(DLEN_ERR), .CS_REQ(CS_REQ), .TX_BIT(TX_BIT), .ECHO_STROBE(ECHO_STROBE),
    .SLAVE_READY_N(SLAVE_READY_N), .TX_PIN(TX_PIN), .CS_N(CS_N), .XFER_GO(XFER_GO),
    .IRQ(IRQ));
  slave_model i_slave (.clk(CLK), .cs_n(CS_N), .delay(dly), .ready_n(SLAVE_READY_N));
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial
  begin
    #20000;
    errors++;
    wrap_up();
  end
  task wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // The wait is open ended; only the watchdog ends a hung transfer.
    do
      @(posedge CLK);
    while (PREADY !== 1'b1);
    q = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task xfer(input logic [15:0] s, input logic p, input logic dl);
    @(posedge CLK);
    XFER_DONE <= 1'b1;
    RX_SHIFT <= s;
    RX_PARITY <= p;
    DLEN_ERR <= dl;
    @(posedge CLK);
    XFER_DONE <= 1'b0;
    DLEN_ERR <= 1'b0;
  endtask : xfer
  task t_reset;
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_INTEN, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(q, 32'h0);
  endtask : t_reset
  task t_word;
    xfer(16'ha5c3, 1'b0, 1'b0);
    rd(ADDR_MIRROR, 32'ha5c3);
    apb(1'b1, ADDR_RXBUF, 32'hffffffff);
    rd(ADDR_RXBUF, 32'ha5c3);
  endtask : t_word
  task t_errs;
    apb(1'b1, ADDR_INTCLR, 32'h1f);
    apb(1'b1, ADDR_INTEN, 32'h0a);
    apb(1'b1, ADDR_CTRL, 32'h0814);
    xfer(16'h5a00, 1'b1, 1'b1);
    rd(ADDR_MIRROR, 32'h5a);
    chk(32'(IRQ), 32'h1);
    rd(ADDR_RXBUF, 32'h0500005a);
    rd(ADDR_RXBUF, 32'h5a);
    rd(ADDR_INTSTAT, 32'h0b);
    apb(1'b1, ADDR_INTCLR, 32'h0a);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0);
    rd(ADDR_INTSTAT, 32'h01);
  endtask : t_errs
  task t_echo;
    apb(1'b1, ADDR_CTRL, 32'h0800);
    xfer(16'h12ab, 1'b0, 1'b0);
    TX_PIN <= 1'b0;
    repeat (3) @(posedge CLK);
    ECHO_STROBE <= 1'b1;
    TX_BIT <= 1'b1;
    @(posedge CLK);
    ECHO_STROBE <= 1'b0;
    repeat (4) @(posedge CLK);
    TX_PIN <= 1'b1;
    rd(ADDR_RXBUF, 32'h100000ab);
  endtask : t_echo
  task t_ready;
    dly <= 8'h03;
    apb(1'b1, ADDR_CTRL, 32'h1003);
    CS_REQ <= 1'b1;
    n = 0;
    while (XFER_GO !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    chk({CS_N, XFER_GO}, 32'h1);
    CS_REQ <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(32'(CS_N), 32'h1);
    rd(ADDR_RXBUF, 32'hab);
  endtask : t_ready
  task t_tmo;
    dly <= 8'hff;
    CS_REQ <= 1'b1;
    repeat (3) @(posedge CLK);
    chk(32'(CS_N), 32'h0);
    n = 0;
    while (CS_N !== 1'b1 && n < 300)
    begin
      @(posedge CLK);
      n++;
    end
    chk(32'(n > 190 && n < 210), 32'h1);
    repeat (5) @(posedge CLK);
    chk(32'(CS_N), 32'h1);
    CS_REQ <= 1'b0;
    rd(ADDR_INTSTAT, 32'h15);
    apb(1'b1, ADDR_CTRL, 32'h1000);
    rd(ADDR_RXBUF, 32'hab);
  endtask : t_tmo
  task t_direct;
    apb(1'b1, ADDR_CTRL, 32'h1001);
    CS_REQ <= 1'b1;
    repeat (2) @(posedge CLK);
    chk({CS_N, XFER_GO}, 32'h1);
    CS_REQ <= 1'b0;
    repeat (2) @(posedge CLK);
    chk({CS_N, XFER_GO}, 32'h2);
  endtask : t_direct
  task t_race;
    // The length error pulse meets the clearing read at the same edge.
    fork
      apb(1'b0, ADDR_RXBUF, 32'h0);
      begin
        repeat (2) @(posedge CLK);
        DLEN_ERR <= 1'b1;
        @(posedge CLK);
        DLEN_ERR <= 1'b0;
      end
    join
    chk(q, 32'hab);
    rd(ADDR_RXBUF, 32'h010000ab);
    rd(ADDR_RXBUF, 32'hab);
  endtask : t_race
  initial
  begin
    {RST_N, PSEL, PENABLE, PWRITE, XFER_DONE, RX_PARITY, DLEN_ERR, CS_REQ} = '0;
    {TX_BIT, ECHO_STROBE, PADDR, PWDATA, RX_SHIFT} = '0;
    TX_PIN = 1'b1;
    dly = 8'h03;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_word();
    t_errs();
    t_echo();
    t_ready();
    t_tmo();
    t_direct();
    t_race();
    wrap_up();
  end
endmodule : tb
